// *** logic/bit_shift_flag_load_exec.sv ***
`timescale 1ns/100ps
`include "exec_defines.svh"

// Operation
// - overflow-clear branch jumps offset plus one, 1/2 cycles
// - interrupt-flag branches jump on enable set/clear
// - I/O bit set/clear, two cycles, flags kept
// - shift left, zero in, updates Z C N V
// - shift right, zero into bit 7, flags
// - rotate left through carry, updates flags
// - rotate right through carry, updates flags
// - arithmetic shift right keeps sign, flags
// - nibble swap, one cycle, no flags
// - set or clear any single status flag
// - copy register bit into transfer flag
// - copy transfer flag into register bit
// - load via X then increment X, two cycles
// - decrement X then load, two cycles
module bit_shift_flag_load_exec (
  input  wire logic           clk,
  input  wire logic           reset_n,
  input  wire logic           opValid,
  input  wire exec_pkg::op_t  opCode,
  input  wire logic [4:0]     dstSel,
  input  wire logic [4:0]     srcSel,
  input  wire logic [2:0]     bitSel,
  input  wire logic [7:0]     immData,
  input  wire logic [6:0]     branchOffset,
  input  wire logic [5:0]     ioSel,
  input  wire logic [7:0]     ioRdData,
  input  wire logic [7:0]     memRdData,
  input  wire logic [4:0]     regReadSel,
  output logic                busy,
  output logic [15:0]         pcOut,
  output logic [7:0]          flagsOut,
  output logic [15:0]         memAddr,
  output logic                memRead,
  output logic [5:0]          ioAddr,
  output logic                ioRead,
  output logic                ioWrite,
  output logic [7:0]          ioWrData,
  output logic [7:0]          regReadData
);
  import exec_pkg::*;

  logic [7:0]  regs [`REG_COUNT];
  state_t      stateReg, stateNext;
  logic [15:0] pcReg, pcNext;
  logic [7:0]  flagReg, flagNext;
  logic        busyReg, busyNext;
  logic [15:0] memAddrReg, memAddrNext;
  logic        memReadReg, memReadNext;
  logic [5:0]  ioAddrReg, ioAddrNext;
  logic        ioReadReg, ioReadNext;
  logic        ioWriteReg, ioWriteNext;
  logic [7:0]  ioWdReg, ioWdNext;
  logic [7:0]  regOutReg;
  logic [4:0]  pendDstReg, pendDstNext;
  logic [7:0]  pendMaskReg, pendMaskNext;
  logic        pendSetReg, pendSetNext;
  logic        regWe, pairWe;
  logic [4:0]  regWa, pairWa;
  logic [7:0]  regWd;
  logic [15:0] pairWd;
  logic [7:0]  dstVal, srcVal;
  logic [15:0] xPtr, offExt;
  logic        issue, branchTake;
  shift_mode_t shMode;
  logic [7:0]  shResult;
  logic        shCarry, shZero, shNeg, shOvf;

  ////////////////////////////////////////////////////////////////////////////
  // operand fetch and decode helpers
  assign dstVal = regs[dstSel];
  assign srcVal = regs[srcSel];
  assign xPtr   = {regs[`X_PAIR_BASE + 5'h01], regs[`X_PAIR_BASE]};
  assign offExt = {{9{branchOffset[`OFFSET_SIGN]}}, branchOffset};
  assign issue  = opValid && !busyReg;

  // branch condition from the flags as they stand now
  always_comb begin
    unique case (opCode)
      OP_BRANCH_OVERFLOW_CLEAR: branchTake = !flagReg[`FLAG_V];
      OP_BRANCH_IRQ_ON:         branchTake = flagReg[`FLAG_I];
      OP_BRANCH_IRQ_OFF:        branchTake = !flagReg[`FLAG_I];
      default:                  branchTake = 1'b0;
    endcase
  end

  // shifter mode from the operation
  always_comb begin
    unique case (opCode)
      OP_LOGIC_SHIFT_RIGHT:  shMode = SH_RIGHT;
      OP_ROTATE_LEFT_CARRY:  shMode = SH_ROT_LEFT;
      OP_ROTATE_RIGHT_CARRY: shMode = SH_ROT_RIGHT;
      OP_ARITH_SHIFT_RIGHT:  shMode = SH_ARITH_RIGHT;
      default:               shMode = SH_LEFT;
    endcase
  end

  shift_unit shifter (
    .mode     (shMode),
    .operand  (dstVal),
    .carryIn  (flagReg[`FLAG_C]),
    .result   (shResult),
    .carryOut (shCarry),
    .zeroOut  (shZero),
    .negOut   (shNeg),
    .ovfOut   (shOvf)
  );

  ////////////////////////////////////////////////////////////////////////////
  // next-state and datapath control
  always_comb begin
    stateNext    = stateReg;
    pcNext       = pcReg;
    flagNext     = flagReg;
    memAddrNext  = memAddrReg;
    memReadNext  = 1'b0;
    ioAddrNext   = ioAddrReg;
    ioReadNext   = 1'b0;
    ioWriteNext  = 1'b0;
    ioWdNext     = ioWdReg;
    pendDstNext  = pendDstReg;
    pendMaskNext = pendMaskReg;
    pendSetNext  = pendSetReg;
    regWe        = 1'b0;
    regWa        = dstSel;
    regWd        = dstVal;
    pairWe       = 1'b0;
    pairWa       = {dstSel[4:1], 1'b0};
    pairWd       = {regs[{srcSel[4:1], 1'b1}], regs[{srcSel[4:1], 1'b0}]};
    unique case (stateReg)
      ST_IDLE: begin
        if (issue) begin
          pcNext = pcReg + `PC_STEP;
          unique case (opCode)
            OP_BRANCH_OVERFLOW_CLEAR, OP_BRANCH_IRQ_ON, OP_BRANCH_IRQ_OFF: begin
              if (branchTake) begin
                pcNext    = pcReg + offExt + `PC_STEP;
                stateNext = ST_BRANCH_WAIT;
              end
            end
            OP_IO_BIT_SET, OP_IO_BIT_CLEAR: begin
              ioAddrNext   = ioSel;
              ioReadNext   = 1'b1;
              pendMaskNext = 8'h01 << bitSel;
              pendSetNext  = (opCode == OP_IO_BIT_SET);
              stateNext    = ST_IO_MODIFY;
            end
            OP_LOGIC_SHIFT_LEFT, OP_LOGIC_SHIFT_RIGHT, OP_ROTATE_LEFT_CARRY,
            OP_ROTATE_RIGHT_CARRY, OP_ARITH_SHIFT_RIGHT: begin
              regWe              = 1'b1;
              regWd              = shResult;
              flagNext[`FLAG_C]  = shCarry;
              flagNext[`FLAG_Z]  = shZero;
              flagNext[`FLAG_N]  = shNeg;
              flagNext[`FLAG_V]  = shOvf;
            end
            OP_NIBBLE_SWAP: begin
              regWe = 1'b1;
              regWd = {dstVal[3:0], dstVal[7:4]};
            end
            OP_FLAG_SET_INDEXED:   flagNext[bitSel] = 1'b1;
            OP_FLAG_CLEAR_INDEXED: flagNext[bitSel] = 1'b0;
            OP_BIT_TO_TRANSFER_FLAG: flagNext[`FLAG_T] = srcVal[bitSel];
            OP_TRANSFER_FLAG_TO_BIT: begin
              regWe         = 1'b1;
              regWd[bitSel] = flagReg[`FLAG_T];
            end
            OP_REG_MOVE: begin
              regWe = 1'b1;
              regWd = srcVal;
            end
            OP_REGISTER_PAIR_COPY: pairWe = 1'b1;
            OP_IMMEDIATE_LOAD: begin
              regWe = 1'b1;
              regWd = immData;
            end
            OP_INDIRECT_LOAD, OP_INDIRECT_LOAD_INC, OP_INDIRECT_LOAD_DEC: begin
              memReadNext = 1'b1;
              pendDstNext = dstSel;
              stateNext   = ST_LOAD_CAPTURE;
              pairWa      = `X_PAIR_BASE;
              memAddrNext = xPtr;
              if (opCode == OP_INDIRECT_LOAD_INC) begin
                pairWe = 1'b1;
                pairWd = xPtr + `PTR_STEP;
              end else if (opCode == OP_INDIRECT_LOAD_DEC) begin
                pairWe      = 1'b1;
                pairWd      = xPtr - `PTR_STEP;
                memAddrNext = xPtr - `PTR_STEP;
              end
            end
            default: ;
          endcase
        end
      end
      ST_BRANCH_WAIT: stateNext = ST_IDLE;
      ST_IO_MODIFY: begin
        ioWriteNext = 1'b1;
        ioWdNext    = pendSetReg ? (ioRdData | pendMaskReg)
                                 : (ioRdData & ~pendMaskReg);
        stateNext   = ST_IDLE;
      end
      ST_LOAD_CAPTURE: begin
        regWe     = 1'b1;
        regWa     = pendDstReg;
        regWd     = memRdData;
        stateNext = ST_IDLE;
      end
    endcase
    busyNext = (stateNext != ST_IDLE);
  end

  ////////////////////////////////////////////////////////////////////////////
  // control registers
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      stateReg    <= ST_IDLE;
      pcReg       <= `PC_RESET;
      flagReg     <= `FLAGS_RESET;
      busyReg     <= 1'b0;
      memAddrReg  <= `PC_RESET;
      memReadReg  <= 1'b0;
      ioAddrReg   <= 6'h00;
      ioReadReg   <= 1'b0;
      ioWriteReg  <= 1'b0;
      ioWdReg     <= `BYTE_ZERO;
      pendDstReg  <= 5'h00;
      pendMaskReg <= `BYTE_ZERO;
      pendSetReg  <= 1'b0;
      regOutReg   <= `BYTE_ZERO;
    end else begin
      stateReg    <= stateNext;
      pcReg       <= pcNext;
      flagReg     <= flagNext;
      busyReg     <= busyNext;
      memAddrReg  <= memAddrNext;
      memReadReg  <= memReadNext;
      ioAddrReg   <= ioAddrNext;
      ioReadReg   <= ioReadNext;
      ioWriteReg  <= ioWriteNext;
      ioWdReg     <= ioWdNext;
      pendDstReg  <= pendDstNext;
      pendMaskReg <= pendMaskNext;
      pendSetReg  <= pendSetNext;
      regOutReg   <= regs[regReadSel];
    end
  end

  // general registers, a byte port and a pair port; byte port wins on overlap
  always_ff @(posedge clk) begin
    if (pairWe) begin
      regs[pairWa]         <= pairWd[7:0];
      regs[pairWa + 5'h01] <= pairWd[15:8];
    end
    if (regWe) begin
      regs[regWa] <= regWd;
    end
  end

  assign busy        = busyReg;
  assign pcOut       = pcReg;
  assign flagsOut    = flagReg;
  assign memAddr     = memAddrReg;
  assign memRead     = memReadReg;
  assign ioAddr      = ioAddrReg;
  assign ioRead      = ioReadReg;
  assign ioWrite     = ioWriteReg;
  assign ioWrData    = ioWdReg;
  assign regReadData = regOutReg;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  AST_BRANCH_OVF_TAKEN: assert property (@(posedge clk) disable iff (!reset_n)
    issue && opCode == OP_BRANCH_OVERFLOW_CLEAR && !flagReg[`FLAG_V]
    |=> pcReg == $past(pcReg) + $past(offExt) + `PC_STEP && busyReg ##1 !busyReg)
    else $error("overflow-clear branch target or timing wrong");

  AST_BRANCH_IRQ_FLAGS: assert property (@(posedge clk) disable iff (!reset_n)
    issue && (opCode == OP_BRANCH_IRQ_ON || opCode == OP_BRANCH_IRQ_OFF)
    |=> flagReg == $past(flagReg) &&
        busyReg == (($past(opCode) == OP_BRANCH_IRQ_ON) == $past(flagReg[`FLAG_I])))
    else $error("interrupt branch taken wrongly or flags changed");

  AST_BRANCH_NOT_TAKEN: assert property (@(posedge clk) disable iff (!reset_n)
    issue && opCode == OP_BRANCH_OVERFLOW_CLEAR && flagReg[`FLAG_V]
    |=> !busyReg && pcReg == $past(pcReg) + `PC_STEP)
    else $error("untaken branch not one cycle");

  AST_IO_SEQUENCE: assert property (@(posedge clk) disable iff (!reset_n)
    issue && (opCode == OP_IO_BIT_SET || opCode == OP_IO_BIT_CLEAR)
    |=> ioReadReg && !ioWriteReg ##1 ioWriteReg && !busyReg && flagReg == $past(flagReg, 2))
    else $error("io bit update not two cycles");

  AST_IO_VALUE: assert property (@(posedge clk) disable iff (!reset_n)
    ioWriteReg |-> ioWdReg == ($past(pendSetReg) ? ($past(ioRdData) | $past(pendMaskReg))
                                                 : ($past(ioRdData) & ~$past(pendMaskReg))))
    else $error("io bit update value wrong");

  AST_SHIFT_LEFT: assert property (@(posedge clk) disable iff (!reset_n)
    issue && opCode == OP_LOGIC_SHIFT_LEFT
    |=> flagReg[`FLAG_C] == $past(dstVal[`SIGN_BIT]) && !busyReg &&
        regs[$past(dstSel)] == {$past(dstVal[6:0]), 1'b0} &&
        flagReg[7:4] == $past(flagReg[7:4]))
    else $error("shift left result or flags wrong");

  AST_ROTATE_RIGHT: assert property (@(posedge clk) disable iff (!reset_n)
    issue && opCode == OP_ROTATE_RIGHT_CARRY
    |=> regs[$past(dstSel)] == {$past(flagReg[`FLAG_C]), $past(dstVal[7:1])} &&
        flagReg[`FLAG_C] == $past(dstVal[0]))
    else $error("rotate right wrong");

  AST_SWAP: assert property (@(posedge clk) disable iff (!reset_n)
    issue && opCode == OP_NIBBLE_SWAP
    |=> regs[$past(dstSel)] == {$past(dstVal[3:0]), $past(dstVal[7:4])} &&
        flagReg == $past(flagReg))
    else $error("nibble swap wrong");

  AST_BIT_STORE: assert property (@(posedge clk) disable iff (!reset_n)
    issue && opCode == OP_BIT_TO_TRANSFER_FLAG
    |=> flagReg[`FLAG_T] == $past(srcVal[bitSel]) && flagReg[5:0] == $past(flagReg[5:0]))
    else $error("bit store to transfer flag wrong");

  AST_LOAD_INC: assert property (@(posedge clk) disable iff (!reset_n)
    issue && opCode == OP_INDIRECT_LOAD_INC
    |=> memReadReg && memAddrReg == $past(xPtr) && xPtr == $past(xPtr) + `PTR_STEP
    ##1 !busyReg && regs[$past(dstSel, 2)] == $past(memRdData))
    else $error("post-increment load wrong");

  AST_LOAD_DEC: assert property (@(posedge clk) disable iff (!reset_n)
    issue && opCode == OP_INDIRECT_LOAD_DEC
    |=> memReadReg && memAddrReg == $past(xPtr) - `PTR_STEP && xPtr == memAddrReg
    ##1 !busyReg)
    else $error("pre-decrement load wrong");

endmodule

// *** logic/exec_defines.svh ***
`ifndef EXEC_DEFINES_SVH
`define EXEC_DEFINES_SVH

// status flag bit positions
`define FLAG_C 0
`define FLAG_Z 1
`define FLAG_N 2
`define FLAG_V 3
`define FLAG_S 4
`define FLAG_H 5
`define FLAG_T 6
`define FLAG_I 7

// reset values
`define FLAGS_RESET 8'h00
`define PC_RESET    16'h0000
`define BYTE_ZERO   8'h00

// register file geometry
`define REG_COUNT   32
`define X_PAIR_BASE 5'h1A

// operand bit positions and step sizes
`define SIGN_BIT    7
`define OFFSET_SIGN 6
`define PC_STEP     16'h0001
`define PTR_STEP    16'h0001

`endif

// *** logic/exec_pkg.sv ***
package exec_pkg;

  // decoded operations handled by this unit
  typedef enum logic [4:0] {
    OP_NOP,
    OP_BRANCH_OVERFLOW_CLEAR,
    OP_BRANCH_IRQ_ON,
    OP_BRANCH_IRQ_OFF,
    OP_IO_BIT_SET,
    OP_IO_BIT_CLEAR,
    OP_LOGIC_SHIFT_LEFT,
    OP_LOGIC_SHIFT_RIGHT,
    OP_ROTATE_LEFT_CARRY,
    OP_ROTATE_RIGHT_CARRY,
    OP_ARITH_SHIFT_RIGHT,
    OP_NIBBLE_SWAP,
    OP_FLAG_SET_INDEXED,
    OP_FLAG_CLEAR_INDEXED,
    OP_BIT_TO_TRANSFER_FLAG,
    OP_TRANSFER_FLAG_TO_BIT,
    OP_REG_MOVE,
    OP_REGISTER_PAIR_COPY,
    OP_IMMEDIATE_LOAD,
    OP_INDIRECT_LOAD,
    OP_INDIRECT_LOAD_INC,
    OP_INDIRECT_LOAD_DEC
  } op_t;

  // shifter modes
  typedef enum logic [2:0] {
    SH_LEFT,
    SH_RIGHT,
    SH_ROT_LEFT,
    SH_ROT_RIGHT,
    SH_ARITH_RIGHT
  } shift_mode_t;

  // execution sequencer states
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_BRANCH_WAIT,
    ST_IO_MODIFY,
    ST_LOAD_CAPTURE
  } state_t;

endpackage

// *** logic/shift_unit.sv ***
`timescale 1ns/100ps
`include "exec_defines.svh"

module shift_unit (
  input  wire exec_pkg::shift_mode_t mode,
  input  wire logic [7:0]            operand,
  input  wire logic                  carryIn,
  output logic [7:0]                 result,
  output logic                       carryOut,
  output logic                       zeroOut,
  output logic                       negOut,
  output logic                       ovfOut
);
  import exec_pkg::*;

  // shift or rotate by one place, carry takes the bit pushed out
  always_comb begin
    unique case (mode)
      SH_LEFT: begin
        result   = {operand[6:0], 1'b0};
        carryOut = operand[`SIGN_BIT];
      end
      SH_RIGHT: begin
        result   = {1'b0, operand[7:1]};
        carryOut = operand[0];
      end
      SH_ROT_LEFT: begin
        result   = {operand[6:0], carryIn};
        carryOut = operand[`SIGN_BIT];
      end
      SH_ROT_RIGHT: begin
        result   = {carryIn, operand[7:1]};
        carryOut = operand[0];
      end
      SH_ARITH_RIGHT: begin
        result   = {operand[`SIGN_BIT], operand[7:1]};
        carryOut = operand[0];
      end
      default: begin
        result   = operand;
        carryOut = carryIn;
      end
    endcase
  end

  // derived flags of the shifted value
  assign zeroOut = (result == `BYTE_ZERO);
  assign negOut  = result[`SIGN_BIT];
  assign ovfOut  = negOut ^ carryOut;

endmodule

// *** tb/tb_top.sv ***
`timescale 1ns/100ps
`include "exec_defines.svh"

module tb_top;
  import exec_pkg::*;

  logic        clk;
  logic        reset_n;
  logic        opValid;
  op_t         opCode;
  logic [4:0]  dstSel;
  logic [4:0]  srcSel;
  logic [2:0]  bitSel;
  logic [7:0]  immData;
  logic [6:0]  branchOffset;
  logic [5:0]  ioSel;
  logic [7:0]  ioRdData;
  logic [7:0]  memRdData;
  logic [4:0]  regReadSel;
  logic        busy;
  logic [15:0] pcOut;
  logic [7:0]  flagsOut;
  logic [15:0] memAddr;
  logic        memRead;
  logic [5:0]  ioAddr;
  logic        ioRead;
  logic        ioWrite;
  logic [7:0]  ioWrData;
  logic [7:0]  regReadData;
  logic [7:0]  ioModel;
  logic [7:0]  memPat;
  logic [15:0] pcExp;
  logic [7:0]  fl;
  int          errors;
  int          nTests;

  bit_shift_flag_load_exec DUT (
    .clk(clk), .reset_n(reset_n), .opValid(opValid), .opCode(opCode), .dstSel(dstSel),
    .srcSel(srcSel), .bitSel(bitSel), .immData(immData), .branchOffset(branchOffset),
    .ioSel(ioSel), .ioRdData(ioRdData), .memRdData(memRdData), .regReadSel(regReadSel),
    .busy(busy), .pcOut(pcOut), .flagsOut(flagsOut), .memAddr(memAddr), .memRead(memRead),
    .ioAddr(ioAddr), .ioRead(ioRead), .ioWrite(ioWrite), .ioWrData(ioWrData),
    .regReadData(regReadData)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // clock and memory or io answers; released lines show the inverse pattern
  always #4 clk = ~clk;
  assign memPat    = memAddr[7:0] ^ memAddr[15:8] ^ 8'h3C;
  assign memRdData = memRead ? memPat : ~memPat;
  assign ioRdData  = ioRead ? ioModel : ~ioModel;

  ////////////////////////////////////////////////////////////////////////////////
  // compare, count and report
  task automatic check(input string name, input logic [15:0] seen, exp);
    nTests++;
    if (seen !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", nTests, errors);
    if (errors == 0 && nTests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // issue one operation; returns one step after the taking edge, opValid still high
  task automatic run_op(input op_t op, input logic [4:0] d, s, input logic [2:0] b,
                        input logic [7:0] imm, input logic [6:0] k);
    opCode = op;
    dstSel = d;
    srcSel = s;
    bitSel = b;
    immData = imm;
    branchOffset = k;
    opValid = 1'b1;
    @(posedge clk);
    #1;
    pcExp = pcExp + 16'h0001;
  endtask

  task automatic immediate_load(input logic [4:0] d, input logic [7:0] v);
    run_op(OP_IMMEDIATE_LOAD, d, 5'h00, 3'h0, v, 7'h00);
  endtask

  task automatic set_flag(input logic [2:0] b, input logic v);
    run_op(v ? OP_FLAG_SET_INDEXED : OP_FLAG_CLEAR_INDEXED, 5'h00, 5'h00, b, 8'h00, 7'h00);
    fl[b] = v;
  endtask

  // debug read port answers one cycle later; no request stands meanwhile
  task automatic chk_reg(input string name, input logic [4:0] idx, input logic [7:0] exp);
    opValid = 1'b0;
    regReadSel = idx;
    @(posedge clk);
    #1;
    check(name, 16'(regReadData), 16'(exp));
  endtask

  // expected shifter result as {carry, value}
  function automatic logic [8:0] shref(input op_t op, input logic [7:0] v, input logic c);
    case (op)
      OP_LOGIC_SHIFT_LEFT:   shref = {v[7], v[6:0], 1'b0};
      OP_LOGIC_SHIFT_RIGHT:  shref = {v[0], 1'b0, v[7:1]};
      OP_ROTATE_LEFT_CARRY:  shref = {v[7], v[6:0], c};
      OP_ROTATE_RIGHT_CARRY: shref = {v[0], c, v[7:1]};
      default:               shref = {v[0], v[7], v[7:1]};
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // watchdog
  initial begin
    #40000;
    errors++;
    complete_run();
  end

  ////////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    op_t        shOps[5];
    logic [7:0] shVals[4];
    op_t        bOp[6];
    logic [2:0] bFlag[6];
    logic [6:0] bK[6];
    op_t        ldOp[3];
    logic [15:0] xStart[3];
    logic [15:0] xAddr;
    logic [15:0] xEnd;
    logic [8:0]  sres;
    logic        fv;
    logic        taken;
    shOps = '{OP_LOGIC_SHIFT_LEFT, OP_LOGIC_SHIFT_RIGHT, OP_ROTATE_LEFT_CARRY,
              OP_ROTATE_RIGHT_CARRY, OP_ARITH_SHIFT_RIGHT};
    shVals = '{8'h96, 8'h81, 8'h00, 8'h7F};
    bOp = '{OP_BRANCH_OVERFLOW_CLEAR, OP_BRANCH_OVERFLOW_CLEAR, OP_BRANCH_IRQ_ON,
            OP_BRANCH_IRQ_ON, OP_BRANCH_IRQ_OFF, OP_BRANCH_IRQ_OFF};
    bFlag = '{`FLAG_V, `FLAG_V, `FLAG_I, `FLAG_I, `FLAG_I, `FLAG_I};
    bK = '{7'h05, 7'h7C, 7'h40, 7'h3F, 7'h7F, 7'h01};
    ldOp = '{OP_INDIRECT_LOAD_INC, OP_INDIRECT_LOAD_DEC, OP_INDIRECT_LOAD};
    xStart = '{16'h12FF, 16'h0000, 16'h0480};
    clk = 1'b0;
    reset_n = 1'b0;
    opValid = 1'b0;
    opCode = OP_NOP;
    dstSel = 5'h00;
    srcSel = 5'h00;
    bitSel = 3'h0;
    immData = 8'h00;
    branchOffset = 7'h00;
    ioSel = 6'h00;
    regReadSel = 5'h00;
    ioModel = 8'h5A;
    pcExp = 16'h0000;
    fl = 8'h00;
    errors = 0;
    nTests = 0;
    repeat (4) @(posedge clk);
    #1;
    reset_n = 1'b1;
    check("pc", pcOut, 16'h0000);
    check("flags", 16'(flagsOut), 16'h0000);
    check("busy", 16'(busy), 16'h0000);
    check("memaddr", memAddr, 16'h0000);
    check("strobes", 16'({memRead, ioRead, ioWrite}), 16'h0000);
    check("ioout", 16'({ioAddr, ioWrData}), 16'h0000);
    check("regread", 16'(regReadData), 16'h0000);
    $display("test reset done");

    // every shift mode against every value, carry alternating
    for (int i = 0; i < 20; i++) begin
      set_flag(`FLAG_C, i[0]);
      immediate_load(5'd16, shVals[i / 5]);
      run_op(shOps[i % 5], 5'd16, 5'h00, 3'h0, 8'h00, 7'h00);
      sres = shref(shOps[i % 5], shVals[i / 5], i[0]);
      fl[`FLAG_C] = sres[8];
      fl[`FLAG_Z] = (sres[7:0] == 8'h00);
      fl[`FLAG_N] = sres[7];
      fl[`FLAG_V] = sres[7] ^ sres[8];
      check("busy", 16'(busy), 16'h0000);
      check("flags", 16'(flagsOut), 16'(fl));
      chk_reg("shift", 5'd16, sres[7:0]);
    end
    immediate_load(5'd17, 8'h3C);
    run_op(OP_NIBBLE_SWAP, 5'd17, 5'h00, 3'h0, 8'h00, 7'h00);
    check("flags", 16'(flagsOut), 16'(fl));
    chk_reg("swap", 5'd17, 8'hC3);
    $display("test shifts done");

    // set then clear every status bit by index
    for (int i = 0; i < 16; i++) begin
      set_flag(i[2:0], !i[3]);
      check("flags", 16'(flagsOut), 16'(fl));
    end
    immediate_load(5'd18, 8'hBF);
    set_flag(`FLAG_T, 1'b1);
    run_op(OP_BIT_TO_TRANSFER_FLAG, 5'h00, 5'd18, 3'd6, 8'h00, 7'h00);
    fl[`FLAG_T] = 1'b0;
    check("flags", 16'(flagsOut), 16'(fl));
    run_op(OP_TRANSFER_FLAG_TO_BIT, 5'd18, 5'h00, 3'd0, 8'h00, 7'h00);
    check("flags", 16'(flagsOut), 16'(fl));
    chk_reg("tbit", 5'd18, 8'hBE);
    run_op(OP_BIT_TO_TRANSFER_FLAG, 5'h00, 5'd18, 3'd7, 8'h00, 7'h00);
    fl[`FLAG_T] = 1'b1;
    check("flags", 16'(flagsOut), 16'(fl));
    run_op(OP_TRANSFER_FLAG_TO_BIT, 5'd18, 5'h00, 3'd6, 8'h00, 7'h00);
    chk_reg("tbit", 5'd18, 8'hFE);
    $display("test flags done");

    // each branch not taken and also taken; offsets of both signs, taken ones too (interrupt-on jumps backward)
    for (int i = 0; i < 6; i++) begin
      fv = i[0] ^ (i > 1);
      set_flag(bFlag[i], fv);
      taken = (bOp[i] == OP_BRANCH_IRQ_ON) ? fv : !fv;
      run_op(bOp[i], 5'h00, 5'h00, 3'h0, 8'h00, bK[i]);
      if (taken) begin
        pcExp = pcExp + {{9{bK[i][6]}}, bK[i]};
      end
      check("pc", pcOut, pcExp);
      check("busy", 16'(busy), 16'(taken));
      check("flags", 16'(flagsOut), 16'(fl));
      opValid = 1'b0;
      @(posedge clk);
      #1;
      check("busy", 16'(busy), 16'h0000);
    end
    $display("test branches done");

    // io bit set at the top end and clear at the bottom end of the io space
    for (int i = 0; i < 2; i++) begin
      ioSel = i[0] ? 6'h00 : 6'h3F;
      run_op(i[0] ? OP_IO_BIT_CLEAR : OP_IO_BIT_SET, 5'h00, 5'h00, i[0] ? 3'd6 : 3'd0,
             8'h00, 7'h00);
      check("ioaddr", 16'(ioAddr), 16'(ioSel));
      check("ioread", 16'({ioRead, ioWrite, busy}), 16'h0005);
      opValid = 1'b0;
      @(posedge clk);
      #1;
      check("iowrite", 16'({ioRead, ioWrite, busy}), 16'h0002);
      check("iodata", 16'(ioWrData), i[0] ? 16'h001A : 16'h005B);
      check("flags", 16'(flagsOut), 16'(fl));
      @(posedge clk);
      #1;
      check("iowrite", 16'(ioWrite), 16'h0000);
    end
    $display("test io done");

    // indirect loads through X, with a refused request in the busy cycle of the first (post-increment) load only
    for (int i = 0; i < 3; i++) begin
      immediate_load(5'd26, xStart[i][7:0]);
      immediate_load(5'd27, xStart[i][15:8]);
      xAddr = (i == 1) ? xStart[i] - 16'h0001 : xStart[i];
      xEnd = (i == 0) ? xStart[i] + 16'h0001 : xAddr;
      run_op(ldOp[i], 5'd20, 5'h00, 3'd5, 8'h00, 7'h00);
      check("memaddr", memAddr, xAddr);
      check("memread", 16'({memRead, busy}), 16'h0003);
      opCode = OP_FLAG_SET_INDEXED;
      opValid = (i == 0);
      @(posedge clk);
      #1;
      check("memread", 16'({memRead, busy}), 16'h0000);
      check("flags", 16'(flagsOut), 16'(fl));
      chk_reg("load", 5'd20, xAddr[7:0] ^ xAddr[15:8] ^ 8'h3C);
      chk_reg("xlow", 5'd26, xEnd[7:0]);
      chk_reg("xhigh", 5'd27, xEnd[15:8]);
    end
    check("pc", pcOut, pcExp);
    $display("test loads done");

    // register move, pair copy of X and a no-op
    run_op(OP_REG_MOVE, 5'd21, 5'd20, 3'h0, 8'h00, 7'h00);
    run_op(OP_REGISTER_PAIR_COPY, 5'd22, 5'd26, 3'h0, 8'h00, 7'h00);
    run_op(OP_NOP, 5'h00, 5'h00, 3'h0, 8'h00, 7'h00);
    check("flags", 16'(flagsOut), 16'(fl));
    check("pc", pcOut, pcExp);
    chk_reg("move", 5'd21, xAddr[7:0] ^ xAddr[15:8] ^ 8'h3C);
    chk_reg("pairlo", 5'd22, xEnd[7:0]);
    chk_reg("pairhi", 5'd23, xEnd[15:8]);
    $display("test moves done");
    complete_run();
  end
endmodule
